// ### verilog/sep_pkg.sv
// Shared constants, field helpers and types of the serial memory slave
package sep_pkg;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned COL_W      = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam int unsigned PAGES      = 16;
  localparam int unsigned MEM_BYTES  = PAGES * PAGE_BYTES;
  localparam int unsigned UID_BITS   = 128;
  localparam int unsigned CS_W       = 3;

  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_EXT  = 4'hB;

  localparam logic [1:0] EXT_SEL_ID   = 2'h0;
  localparam logic [1:0] EXT_SEL_LOCK = 2'h2;
  localparam logic [1:0] EXT_SEL_SOFT = 2'h3;

  localparam logic [3:0] ACK_CNT  = 4'h8;
  localparam logic [3:0] COL_LAST = 4'hF;
  localparam logic [2:0] BIT_MSB  = 3'h7;

  localparam int unsigned PROG_TIME_MS = 3;
  localparam int unsigned CLK_KHZ      = 200000;
  localparam int unsigned PROG_CYCLES  = PROG_TIME_MS * CLK_KHZ;

  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W     = COL_W + BYTE_W;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA, ST_PROG
  } sep_state_e;

  typedef enum logic [1:0] {RG_MAIN, RG_ID, RG_LOCK, RG_SOFT} sep_region_e;

  function automatic logic [3:0] dev_type(input logic [7:0] b);
    return b[7:4];
  endfunction

  function automatic logic [CS_W-1:0] dev_cs(input logic [7:0] b);
    return b[3:1];
  endfunction

  function automatic logic dev_rd(input logic [7:0] b);
    return b[0];
  endfunction

  function automatic sep_region_e ext_region(input logic [7:0] b);
    unique case (b[7:6])
      EXT_SEL_ID:   return RG_ID;
      EXT_SEL_LOCK: return RG_LOCK;
      EXT_SEL_SOFT: return RG_SOFT;
      default:      return RG_ID;
    endcase
  endfunction
endpackage

// ### verilog/sep_fifo_if.sv
// Valid/ready carrier between the byte receiver and the write FIFO
`timescale 1ns/1ps
interface sep_fifo_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface

// ### verilog/sep_fifo.sv
// Small synchronous FIFO with honest full and empty
`timescale 1ns/1ps
module sep_fifo import sep_pkg::*; #(
  parameter int unsigned WIDTH = FIFO_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  sep_fifo_if.fifo f
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign f.wr_ready = (count != (AW+1)'(DEPTH));
  assign f.rd_valid = (count != '0);
  assign f.rd_data  = mem[rd_ptr];
  assign push       = f.wr_valid & f.wr_ready;
  assign pop        = f.rd_valid & f.rd_ready;

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= f.wr_data;
    end
  end
endmodule

// ### verilog/sep_slave.sv
// Two-wire serial memory slave: protocol engine, storage, write cycle
// Operation
// - Sample SDA on SCL rise; change driven SDA only after SCL fall.
// - SDA is open-drain: only pull low or release, never drive high.
// - Three chip-select inputs; unconnected inputs read as zero.
// - Write-guard pin high refuses all array writes; low permits them.
// - With guard high, address bytes are acknowledged, data bytes not.
// - Main storage is 256 bytes: sixteen pages of sixteen bytes.
// - Byte writes and full or partial page writes are accepted.
// - Accepted write runs a self-timed programming cycle of at most 3 ms.
// - Extra sixteen-byte ID page, lockable permanently against writes; here RST_I clears the lock.
// - Read-only 128-bit unique ID returned only by its read command.
// - Software write lock blocks array writes independently of pin.
// - Bus runs at up to 400 kHz and up to 1 MHz.
// - Address byte: type, three select bits, read/write; 1010 or 1011.
// - Ninth clock: acknowledge on type and select match, else standby.
// - Programming starts only on a stop ending a write command.
// - Software lock bit at one protects array and ID page.
`timescale 1ns/1ps
module sep_slave import sep_pkg::*; #(
  parameter int unsigned          P_PROG_CYCLES = PROG_CYCLES,
  // Arbitrary stand-in for the factory identifier
  parameter logic [UID_BITS-1:0] P_UID = 128'h00112233445566778899AABBCCDDEEFF
) (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  input  wire logic CHIP_SELECT_BIT0_I,
  input  wire logic CHIP_SELECT_BIT1_I,
  input  wire logic CHIP_SELECT_BIT2_I,
  input  wire logic WRITE_GUARD_I,
  output logic      SDA_O,
  output logic      SDA_OE_O,
  output logic      BUSY_O,
  output logic      SOFT_WRITE_LOCK_BIT_O,
  output logic      ID_LOCK_O
);
  localparam int unsigned PC_W = $clog2(P_PROG_CYCLES + 1);

  sep_fifo_if #(.W(FIFO_W)) wq ();

  sep_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .f     (wq.fifo)
  );

  logic [BYTE_W-1:0] mem     [MEM_BYTES];
  logic [BYTE_W-1:0] id_page [PAGE_BYTES];
  logic [BYTE_W-1:0] pg_buf  [PAGE_BYTES];

  sep_state_e        state, next_state;
  sep_region_e       region, next_region;
  logic [3:0]        bit_cnt, next_bit_cnt;
  logic              ack_phase, next_ack_phase;
  logic              acked, next_acked;
  logic              is_ext, next_is_ext;
  logic              is_rd, next_is_rd;
  logic [7:0]        shreg, next_shreg;
  logic [7:0]        tx, next_tx;
  logic [7:0]        addr, next_addr;
  logic              drive_low, next_drive_low;
  logic              push_valid, next_push_valid;
  logic [FIFO_W-1:0] push_data, next_push_data;
  logic              pend_wr, next_pend_wr;
  logic              pend_lock, next_pend_lock;
  logic              pend_soft, next_pend_soft;
  logic              soft_val, next_soft_val;
  logic              prog_req, next_prog_req;
  logic [PC_W-1:0]   prog_cnt, next_prog_cnt;
  logic              commit_on, next_commit_on;
  logic [3:0]        commit_idx, next_commit_idx;
  logic [15:0]       pg_mask, next_pg_mask;
  logic              soft_lock, next_soft_lock;
  logic              id_lock, next_id_lock;
  logic              busy, next_busy;
  logic              scl_q, sda_q;
  logic              scl_rise, scl_fall, start_c, stop_c;
  logic [CS_W-1:0]   cs;
  logic              mem_we, id_we, pg_we, prot, ack;
  logic [7:0]        rd_now;

  // Undriven select pins are pulled low on the board side
  assign cs = {CHIP_SELECT_BIT2_I, CHIP_SELECT_BIT1_I, CHIP_SELECT_BIT0_I};

  // Inputs are synchronous; one stage of history finds edges and
  // start/stop. At 1 MHz SCL each half period is ~100 clocks
  assign scl_rise = SCL_I & ~scl_q;
  assign scl_fall = ~SCL_I & scl_q;
  assign start_c  = SCL_I & scl_q & sda_q & ~SDA_I;
  assign stop_c   = SCL_I & scl_q & ~sda_q & SDA_I;

  // Commit stalls the FIFO drain so the page latch holds still
  assign wq.rd_ready = ~(state == ST_PROG && commit_on);
  assign wq.wr_valid = push_valid;
  assign wq.wr_data  = push_data;
  assign pg_we       = wq.rd_valid & wq.rd_ready;

  assign mem_we = (state == ST_PROG) && commit_on && pg_mask[commit_idx]
                  && (region == RG_MAIN);
  assign id_we  = (state == ST_PROG) && commit_on && pg_mask[commit_idx]
                  && (region == RG_ID);

  function automatic logic [7:0] rd_byte(input sep_region_e rg,
                                         input logic [7:0]  a);
    unique case (rg)
      RG_MAIN: return mem[a];
      RG_ID:   return id_page[a[3:0]];
      RG_LOCK: return P_UID[UID_BITS-1-BYTE_W*a[3:0] -: BYTE_W];
      RG_SOFT: return {7'h00, soft_lock};
    endcase
  endfunction

  function automatic logic [7:0] inc(input logic full, input logic [7:0] a);
    return full ? a + 8'h01 : {a[7:4], a[3:0] + 4'h1};
  endfunction

  // A process, not an assign, so writes into the arrays are seen too
  always_comb begin
    rd_now = rd_byte(region, addr);
  end

  always_comb begin
    prot = WRITE_GUARD_I;
    if (region != RG_SOFT) begin
      prot = prot | soft_lock;
    end
    if (region == RG_ID || region == RG_LOCK) begin
      prot = prot | id_lock;
    end
  end

  always_comb begin
    next_state      = state;
    next_region     = region;
    next_bit_cnt    = bit_cnt;
    next_ack_phase  = ack_phase;
    next_acked      = acked;
    next_is_ext     = is_ext;
    next_is_rd      = is_rd;
    next_shreg      = shreg;
    next_tx         = tx;
    next_addr       = addr;
    next_drive_low  = drive_low;
    next_push_valid = 1'h0;
    next_push_data  = push_data;
    next_pend_wr    = pend_wr;
    next_pend_lock  = pend_lock;
    next_pend_soft  = pend_soft;
    next_soft_val   = soft_val;
    next_prog_req   = prog_req;
    next_prog_cnt   = prog_cnt;
    next_commit_on  = commit_on;
    next_commit_idx = commit_idx;
    next_pg_mask    = pg_mask;
    next_soft_lock  = soft_lock;
    next_id_lock    = id_lock;
    ack             = 1'h0;
    if (pg_we) begin
      next_pg_mask[wq.rd_data[FIFO_W-1 -: COL_W]] = 1'h1;
    end
    if (start_c && state != ST_PROG && !prog_req) begin
      // Busy device ignores starts, so the address goes unanswered
      next_state     = ST_DEV;
      next_bit_cnt   = '0;
      next_ack_phase = 1'h0;
      next_drive_low = 1'h0;
    end else if (stop_c && state != ST_PROG) begin
      if (state == ST_WDATA && (pend_wr || pend_lock || pend_soft)) begin
        next_prog_req = 1'h1;
      end
      next_state     = ST_IDLE;
      next_bit_cnt   = '0;
      next_ack_phase = 1'h0;
      next_drive_low = 1'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Wait for the FIFO to drain before the page is committed
          if (prog_req && !wq.rd_valid) begin
            next_state      = ST_PROG;
            next_prog_req   = 1'h0;
            next_prog_cnt   = '0;
            next_commit_on  = 1'h1;
            next_commit_idx = '0;
          end
        end
        ST_DEV, ST_WADDR, ST_WDATA: begin
          if (scl_rise && bit_cnt < ACK_CNT) begin
            next_shreg   = {shreg[6:0], SDA_I};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == ACK_CNT && !ack_phase) begin
            if (state == ST_DEV) begin
              ack = (dev_cs(shreg) == cs) &&
                    (dev_type(shreg) == TYPE_MAIN ||
                     dev_type(shreg) == TYPE_EXT);
              next_is_ext = (dev_type(shreg) == TYPE_EXT);
              next_is_rd  = dev_rd(shreg);
              if (ack && dev_type(shreg) == TYPE_MAIN) begin
                next_region = RG_MAIN;
              end
            end else if (state == ST_WADDR) begin
              ack         = 1'h1;
              next_addr   = shreg;
              next_region = is_ext ? ext_region(shreg) : RG_MAIN;
            end else begin
              ack = !prot && wq.wr_ready;
              if (ack) begin
                unique case (region)
                  RG_MAIN, RG_ID: begin
                    next_push_valid = 1'h1;
                    next_push_data  = {addr[3:0], shreg};
                    next_addr       = inc(1'h0, addr);
                    next_pend_wr    = 1'h1;
                  end
                  RG_LOCK: next_pend_lock = 1'h1;
                  RG_SOFT: begin
                    next_pend_soft = 1'h1;
                    next_soft_val  = shreg[0];
                  end
                endcase
              end
            end
            next_ack_phase = 1'h1;
            next_acked     = ack;
            next_drive_low = ack;
          end else if (scl_fall && ack_phase) begin
            next_ack_phase = 1'h0;
            next_bit_cnt   = '0;
            next_drive_low = 1'h0;
            if (state == ST_DEV) begin
              if (!acked) begin
                next_state = ST_IDLE;
              end else if (is_rd) begin
                next_state     = ST_RDATA;
                next_tx        = rd_now;
                next_drive_low = ~rd_now[BIT_MSB];
                next_addr      = inc(region == RG_MAIN, addr);
              end else begin
                next_state     = ST_WADDR;
                next_pend_wr   = 1'h0;
                next_pend_lock = 1'h0;
                next_pend_soft = 1'h0;
              end
            end else if (state == ST_WADDR) begin
              next_state = ST_WDATA;
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            if (bit_cnt < ACK_CNT) begin
              next_bit_cnt = bit_cnt + 4'h1;
            end else if (SDA_I) begin
              next_state = ST_IDLE;                    // Master ended read
            end else begin
              next_bit_cnt = '0;
              next_tx      = rd_now;
              next_addr    = inc(region == RG_MAIN, addr);
            end
          end else if (scl_fall) begin
            next_drive_low = (bit_cnt < ACK_CNT) &&
                             ~tx[BIT_MSB - bit_cnt[2:0]];
          end
        end
        ST_PROG: begin
          next_prog_cnt = prog_cnt + PC_W'(1);
          if (commit_on) begin
            next_commit_idx = commit_idx + 4'h1;
            next_commit_on  = (commit_idx != COL_LAST);
          end
          if (prog_cnt == PC_W'(P_PROG_CYCLES - 1)) begin
            next_state     = ST_IDLE;
            next_pg_mask   = '0;
            next_pend_wr   = 1'h0;
            next_pend_lock = 1'h0;
            next_pend_soft = 1'h0;
            if (pend_lock) begin
              next_id_lock = 1'h1;
            end
            if (pend_soft) begin
              next_soft_lock = soft_val;
            end
          end
        end
      endcase
    end
    next_busy = (next_state == ST_PROG) || next_prog_req;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state      <= ST_IDLE;
      region     <= RG_MAIN;
      bit_cnt    <= '0;
      ack_phase  <= 1'h0;
      acked      <= 1'h0;
      is_ext     <= 1'h0;
      is_rd      <= 1'h0;
      shreg      <= '0;
      tx         <= '0;
      addr       <= '0;
      drive_low  <= 1'h0;
      push_valid <= 1'h0;
      push_data  <= '0;
      pend_wr    <= 1'h0;
      pend_lock  <= 1'h0;
      pend_soft  <= 1'h0;
      soft_val   <= 1'h0;
      prog_req   <= 1'h0;
      prog_cnt   <= '0;
      commit_on  <= 1'h0;
      commit_idx <= '0;
      pg_mask    <= '0;
      soft_lock  <= 1'h0;
      id_lock    <= 1'h0;
      busy       <= 1'h0;
      scl_q      <= 1'h1;
      sda_q      <= 1'h1;
    end else begin
      state      <= next_state;
      region     <= next_region;
      bit_cnt    <= next_bit_cnt;
      ack_phase  <= next_ack_phase;
      acked      <= next_acked;
      is_ext     <= next_is_ext;
      is_rd      <= next_is_rd;
      shreg      <= next_shreg;
      tx         <= next_tx;
      addr       <= next_addr;
      drive_low  <= next_drive_low;
      push_valid <= next_push_valid;
      push_data  <= next_push_data;
      pend_wr    <= next_pend_wr;
      pend_lock  <= next_pend_lock;
      pend_soft  <= next_pend_soft;
      soft_val   <= next_soft_val;
      prog_req   <= next_prog_req;
      prog_cnt   <= next_prog_cnt;
      commit_on  <= next_commit_on;
      commit_idx <= next_commit_idx;
      pg_mask    <= next_pg_mask;
      soft_lock  <= next_soft_lock;
      id_lock    <= next_id_lock;
      busy       <= next_busy;
      scl_q      <= SCL_I;
      sda_q      <= SDA_I;
    end
  end

  // Storage has no reset: contents survive like the cells they model
  always_ff @(posedge CLK_I) begin
    if (pg_we) begin
      pg_buf[wq.rd_data[FIFO_W-1 -: COL_W]] <= wq.rd_data[BYTE_W-1:0];
    end
    if (mem_we) begin
      mem[{addr[7:4], commit_idx}] <= pg_buf[commit_idx];
    end
    if (id_we) begin
      id_page[commit_idx] <= pg_buf[commit_idx];
    end
  end

  always_ff @(posedge CLK_I) begin
    SDA_O <= 1'h0;
  end

  assign SDA_OE_O              = drive_low;
  assign BUSY_O                = busy;
  assign SOFT_WRITE_LOCK_BIT_O = soft_lock;
  assign ID_LOCK_O             = id_lock;
endmodule

// ### verification/sep_checker.sv
// Port-level assertions for the serial memory slave
`timescale 1ns/1ps
module sep_checker import sep_pkg::*; #(
  parameter int unsigned P_PROG_CYCLES = PROG_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic CHIP_SELECT_BIT0_I,
  input wire logic CHIP_SELECT_BIT1_I,
  input wire logic CHIP_SELECT_BIT2_I,
  input wire logic WRITE_GUARD_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic BUSY_O,
  input wire logic SOFT_WRITE_LOCK_BIT_O,
  input wire logic ID_LOCK_O
);
  int unsigned since_stop;
  int unsigned busy_len;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Saturates so a long idle spell cannot wrap back to a small count
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      since_stop <= 100;
      busy_len   <= 0;
    end else begin
      if (SCL_I && SDA_I && $past(SCL_I) && !$past(SDA_I)) begin
        since_stop <= 0;
      end else if (since_stop < 100) begin
        since_stop <= since_stop + 1;
      end
      busy_len <= BUSY_O ? busy_len + 1 : 0;
    end
  end
  sequence s_stop;
    SCL_I && !SDA_I ##1 SCL_I && SDA_I;
  endsequence
  property p_open_drain;
    SDA_OE_O |-> !SDA_O;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("slave drives data line high");
  property p_oe_scl_low;
    $changed(SDA_OE_O) |-> !$past(SCL_I) && $past(SCL_I, 2);
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed outside clock low phase");
  property p_stop_idle;
    s_stop |=> !SDA_OE_O [*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("slave drives data line after stop");
  property p_busy_quiet;
    BUSY_O |-> !SDA_OE_O;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("slave answers while programming");
  property p_busy_after_stop;
    $rose(BUSY_O) |-> since_stop <= 4;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop)
    else $error("programming began without a stop");
  property p_busy_cap;
    BUSY_O |-> busy_len < P_PROG_CYCLES + 16;
  endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("programming cycle overran its time");
  property p_busy_full;
    $fell(BUSY_O) |-> busy_len >= P_PROG_CYCLES;
  endproperty
  a_busy_full: assert property (p_busy_full)
    else $error("programming cycle ended early");
  property p_lock_at_end;
    $changed(SOFT_WRITE_LOCK_BIT_O) || $changed(ID_LOCK_O)
      |-> !BUSY_O && ($past(BUSY_O) || $past(BUSY_O, 2));
  endproperty
  a_lock_at_end: assert property (p_lock_at_end)
    else $error("lock state changed outside end of programming");
  property p_id_sticky;
    ID_LOCK_O |=> ID_LOCK_O;
  endproperty
  a_id_sticky: assert property (p_id_sticky)
    else $error("identification page lock was lost");
endmodule

// ### verification/sep_master_model.sv
// Behavioural two-wire bus master driving the slave's serial link
`timescale 1ns/1ps
module sep_master_model #(
  parameter int HALF = 8
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end
  // Half period well above the slave's three-cycle minimum
  task automatic tick();
    repeat (HALF) @(negedge clk_i);
  endtask
  task automatic start();
    pull_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    pull_o = 1'b1;
    tick();
    scl_o = 1'b0;
    tick();
  endtask
  task automatic stop();
    pull_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    pull_o = 1'b0;
    tick();
  endtask
  // Data only moves while the clock is low
  task automatic bit_out(input logic b);
    pull_o = !b;
    tick();
    scl_o = 1'b1;
    tick();
    scl_o = 1'b0;
  endtask
  task automatic bit_in(output logic v);
    pull_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    v = sda_i;
    scl_o = 1'b0;
  endtask
  // Most significant bit first
  task automatic send(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    bit_in(v);
    ack = !v;
  endtask
  task automatic recv(output logic [7:0] b, input logic more);
    for (int i = 7; i >= 0; i--) bit_in(b[i]);
    bit_out(!more);
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
module testbench import sep_pkg::*;;
  localparam int unsigned  PROG = 600;
  // Arbitrary identifier value
  localparam logic [127:0] UID  = 128'h0123456789ABCDEF0F1E2D3C4B5A6978;
  logic       clk, rst, guard, scl, pull, sda_o, sda_oe;
  logic       busy, soft_lock, id_lock, a_dev, a_word, a_dat;
  logic [2:0] cs;
  logic [7:0] rb [0:1];
  int         mismatches, checked, cycles;
  wire        sda = !pull && (sda_oe ? sda_o : 1'b1);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sep_slave #(.P_PROG_CYCLES(PROG), .P_UID(UID)) dut (
    .CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .CHIP_SELECT_BIT0_I(cs[0]), .CHIP_SELECT_BIT1_I(cs[1]),
    .CHIP_SELECT_BIT2_I(cs[2]), .WRITE_GUARD_I(guard), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .BUSY_O(busy), .SOFT_WRITE_LOCK_BIT_O(soft_lock),
    .ID_LOCK_O(id_lock));
  sep_master_model m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic probe(input logic [7:0] b, input logic e, input string w);
    m.start();
    m.send(b, a_dev);
    m.stop();
    check(w, {7'h0, a_dev}, {7'h0, e});
  endtask
  task automatic wr(input [3:0] ty, input [7:0] wa, d, input int n);
    logic a;
    m.start();
    m.send({ty, cs, 1'b0}, a_dev);
    m.send(wa, a_word);
    a_dat = 1'b1;
    for (int i = 0; i < n; i++) begin
      m.send(d + 8'(i), a);
      a_dat &= a;
    end
    m.stop();
  endtask
  task automatic rd(input [3:0] ty, input [7:0] wa, input int n);
    m.start();
    m.send({ty, cs, 1'b0}, a_dev);
    m.send(wa, a_word);
    m.start();
    m.send({ty, cs, 1'b1}, a_dev);
    check("ack read", {7'h0, a_dev}, 8'h01);
    for (int i = 0; i < n; i++) m.recv(rb[i], i < n - 1);
    m.stop();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < PROG + 100 && busy !== 1'b0; i++) @(negedge clk);
    check("busy end", {7'h0, busy}, 8'h00);
  endtask
  task automatic test_addr();
    for (int k = 0; k < 8; k++) begin
      cs = 3'(k);
      probe({4'hA, cs, 1'b0}, 1'b1, "ack main");
      // Write probe: a read probe leaves the slave driving into the stop
      probe({4'hB, cs, 1'b0}, 1'b1, "ack ext");
      probe({4'hA, ~cs, 1'b0}, 1'b0, "nack select");
    end
    probe({4'h5, cs, 1'b0}, 1'b0, "nack type");
    $display("test addr done");
  endtask
  task automatic test_page();
    // Starts two bytes before the page end so the wrap is exercised
    wr(4'hA, 8'hFE, 8'h10, 4);
    check("acks", {5'h0, a_dev, a_word, a_dat}, 8'h07);
    check("busy", {7'h0, busy}, 8'h01);
    probe({4'hA, cs, 1'b0}, 1'b0, "poll");
    wait_idle();
    rd(4'hA, 8'hFE, 2);
    check("byte FE", rb[0], 8'h10);
    check("byte FF", rb[1], 8'h11);
    rd(4'hA, 8'hF0, 2);
    check("byte F0", rb[0], 8'h12);
    check("byte F1", rb[1], 8'h13);
    wr(4'hA, 8'h00, 8'h77, 1);
    wait_idle();
    rd(4'hA, 8'h00, 1);
    check("byte 00", rb[0], 8'h77);
    $display("test page done");
  endtask
  task automatic test_guard();
    guard = 1'b1;
    wr(4'hA, 8'hFE, 8'h55, 2);
    check("guard acks", {5'h0, a_dev, a_word, a_dat}, 8'h06);
    wait_idle();
    guard = 1'b0;
    rd(4'hA, 8'hFE, 1);
    check("guarded byte", rb[0], 8'h10);
    $display("test guard done");
  endtask
  task automatic test_soft();
    wr(4'hB, 8'hC0, 8'h01, 1);
    wait_idle();
    check("soft set", {7'h0, soft_lock}, 8'h01);
    wr(4'hA, 8'hFE, 8'h66, 1);
    check("soft array", {7'h0, a_dat}, 8'h00);
    wait_idle();
    wr(4'hB, 8'h05, 8'h66, 1);
    check("soft id", {7'h0, a_dat}, 8'h00);
    wait_idle();
    rd(4'hB, 8'hC0, 1);
    check("soft read", rb[0], 8'h01);
    wr(4'hB, 8'hC0, 8'h00, 1);
    wait_idle();
    check("soft clear", {7'h0, soft_lock}, 8'h00);
    $display("test soft done");
  endtask
  task automatic test_id();
    wr(4'hB, 8'h05, 8'h5A, 1);
    wait_idle();
    rd(4'hB, 8'h05, 1);
    check("id byte", rb[0], 8'h5A);
    wr(4'hB, 8'h80, 8'h00, 1);
    wait_idle();
    check("id lock", {7'h0, id_lock}, 8'h01);
    wr(4'hB, 8'h05, 8'h33, 1);
    check("id refused", {7'h0, a_dat}, 8'h00);
    wait_idle();
    rd(4'hB, 8'h05, 1);
    check("id kept", rb[0], 8'h5A);
    rd(4'hB, 8'h80, 2);
    check("uid 0", rb[0], UID[127:120]);
    check("uid 1", rb[1], UID[119:112]);
    $display("test id done");
  endtask
  initial begin
    rst   = 1'b1;
    cs    = 3'h0;
    guard = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    test_addr();
    test_page();
    test_guard();
    test_soft();
    test_id();
    conclude();
  end
endmodule
bind sep_slave sep_checker #(.P_PROG_CYCLES(P_PROG_CYCLES)) u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
  .CHIP_SELECT_BIT0_I(CHIP_SELECT_BIT0_I),
  .CHIP_SELECT_BIT1_I(CHIP_SELECT_BIT1_I),
  .CHIP_SELECT_BIT2_I(CHIP_SELECT_BIT2_I), .WRITE_GUARD_I(WRITE_GUARD_I),
  .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .BUSY_O(BUSY_O),
  .SOFT_WRITE_LOCK_BIT_O(SOFT_WRITE_LOCK_BIT_O), .ID_LOCK_O(ID_LOCK_O));
